// >>> rtl/dic_pkg.sv
// Purpose: constants for the three-channel digital input conditioner
// Assumes: 100 MHz module clock
// Notes: bit positions of the packed input byte and timing counts
`default_nettype none
package dic_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int MS_PER_S = 1000;
  localparam int US_PER_MS = 1000;
  localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int FWD_PERIOD_US = 6500;
  localparam int FWD_PERIOD_CYCLES = (CLK_HZ / 1000000) * FWD_PERIOD_US;
  localparam int MAX_INPUT_HZ = 50;
  localparam logic [7:0] CONFIG_CODE = 8'h0A;
  localparam int NUM_CH = 3;
  localparam int STATE_BIT0 = 0;
  localparam int FAULT_BIT0 = 1;
  localparam int BITS_PER_CH = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] LF_OK = 2'h0;
  localparam logic [1:0] LF_OPEN = 2'h1;
  localparam logic [1:0] LF_SHORT = 2'h2;
  typedef enum logic [1:0] {
    DIC_FM_CURRENT = 2'b00,
    DIC_FM_SUBST = 2'b01,
    DIC_FM_LAST = 2'b10
  } dic_fault_mode_t;
endpackage
`default_nettype wire

// >>> rtl/dic_conditioner.sv
// Purpose: per-channel conditioning of three binary field inputs into one input byte
// Assumes: field levels and line status are synchronous; configuration is static
// Notes: one clock enable freezes all state
// Operation
// R1: byte packs states bits 0,2,4, faults 1,3,5
// R2: configuration code 10 identifies data structure
// R3: byte forwarded every 6.5 ms
// R4: input path follows signals up to 50 Hz
// R5: per-channel OFF delay stretches short pulses
// R6: per-channel check tells open from short
// R7: line fault check enabled by configuration
// R8: check only meaningful for proximity sensors
// R9: detected fault raises diagnosis, applies strategy
// R10: module fault reflected in status registers
// R11: channel diagnosis carries slot, channel, io, reason
// R12: standard and extended diagnostics offered
// R13: polarity selects closed contact as 0/1
// R14: normal mode reports field signal
// R15: simulation mode reports simulation value
// R16: current-value mode passes present value
// R17: substitute mode passes substitute value
// R18: last-valid mode holds last good value
// R19: ON delay postpones rising transitions
// R20: OFF delay postpones falling transitions
// R21: substitute bit carries valid/invalid status
// R22: invalid simulation status acts as fault
// R23: order polarity, delay, mode, substitution
// R24: delays count ms ticks, restart on return
`default_nettype none
module dic_conditioner
  import dic_pkg::*;
#(
  parameter int DELAY_W = 16,
  parameter int TICK_CYCLES = MS_TICK_CYCLES,
  parameter int FWD_CYCLES = FWD_PERIOD_CYCLES,
  parameter logic [7:0] SLOT_ID = 8'h00 // arbitrary default, set per installation
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NUM_CH-1:0] field_level,
  input wire logic [2*NUM_CH-1:0] line_status,
  input wire logic [NUM_CH-1:0] line_fault_check_en,
  input wire logic [NUM_CH-1:0] closed_is_one,
  input wire logic [NUM_CH-1:0] sim_mode,
  input wire logic [NUM_CH-1:0] sim_value,
  input wire logic [NUM_CH-1:0] sim_invalid,
  input wire logic [2*NUM_CH-1:0] fault_mode,
  input wire logic [NUM_CH-1:0] subst_value,
  input wire logic [NUM_CH-1:0] subst_invalid,
  input wire logic [NUM_CH*DELAY_W-1:0] on_delay_ms,
  input wire logic [NUM_CH*DELAY_W-1:0] off_delay_ms,
  input wire logic diag_status_en,
  output logic [7:0] input_byte,
  output logic input_byte_valid,
  output logic [7:0] config_code,
  output logic module_fault,
  output logic global_fault,
  output logic [NUM_CH-1:0] channel_invalid,
  output logic diag_valid,
  output logic [7:0] diag_slot,
  output logic [1:0] diag_channel,
  output logic diag_is_input,
  output logic [1:0] diag_reason
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int FWD_W = $clog2(FWD_CYCLES + 1);

  // a tick needs one cycle and the forward strobe must drop between periods
  if (TICK_CYCLES < 1 || FWD_CYCLES < 2 || DELAY_W < 1 || DELAY_W > 30)
  begin : g_param_check
    $error("dic_conditioner: unsupported parameter values");
  end

  logic [TICK_W-1:0] tick_cnt;
  logic [FWD_W-1:0] fwd_cnt;
  wire ms_tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1)); // R24
  wire fwd_due = (fwd_cnt == FWD_W'(FWD_CYCLES - 1)); // R3

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt <= '0;
      fwd_cnt <= '0;
    end
    else if (clk_en)
    begin
      tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
      fwd_cnt <= fwd_due ? '0 : fwd_cnt + 1'b1;
    end
  end

  logic [NUM_CH-1:0] cond_bit;
  logic [NUM_CH-1:0] fault_bit;
  logic [NUM_CH-1:0] inval_bit;
  logic [NUM_CH-1:0] delayed;
  logic [NUM_CH-1:0] last_good;
  logic [NUM_CH*DELAY_W-1:0] dly_cnt;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      wire [1:0] lstat = line_status[2*g +: 2];
      wire [DELAY_W-1:0] on_ms = on_delay_ms[g*DELAY_W +: DELAY_W];
      wire [DELAY_W-1:0] off_ms = off_delay_ms[g*DELAY_W +: DELAY_W];
      wire [DELAY_W-1:0] cnt = dly_cnt[g*DELAY_W +: DELAY_W];
      // field level is high for a closed contact
      wire pol = closed_is_one[g] ? field_level[g] : ~field_level[g]; // R13 R23
      wire [DELAY_W-1:0] limit = pol ? on_ms : off_ms; // R19 R20
      wire differs = (pol != delayed[g]);
      wire expire = differs && (limit == '0 || (ms_tick && cnt == limit - 1'b1));
      wire sel = sim_mode[g] ? sim_value[g] : delayed[g]; // R14 R15
      // open/short only checked where enabled, contacts without shunt must leave it off
      wire line_bad = line_fault_check_en[g] && (lstat != LF_OK); // R6 R7 R8
      wire bad = line_bad || (sim_mode[g] && sim_invalid[g]); // R22
      wire [1:0] fm = fault_mode[2*g +: 2];
      logic outv;
      always_comb
      begin
        case (fm)
          DIC_FM_SUBST: outv = bad ? subst_value[g] : sel; // R17
          DIC_FM_LAST: outv = bad ? last_good[g] : sel; // R18
          DIC_FM_CURRENT: outv = sel; // R16
          default: outv = sel;
        endcase
      end
      assign cond_bit[g] = outv;
      assign fault_bit[g] = bad; // R9
      assign inval_bit[g] = bad && (fm == DIC_FM_SUBST) && subst_invalid[g]; // R21

      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          delayed[g] <= 1'b0;
          last_good[g] <= 1'b0;
          dly_cnt[g*DELAY_W +: DELAY_W] <= '0;
        end
        else if (clk_en)
        begin
          // a return to the passed level before expiry restarts the timer
          if (!differs || expire)
            dly_cnt[g*DELAY_W +: DELAY_W] <= '0; // R24
          else if (ms_tick)
            dly_cnt[g*DELAY_W +: DELAY_W] <= cnt + 1'b1;
          if (expire)
            delayed[g] <= pol; // R5 R19 R20
          if (!bad)
            last_good[g] <= sel; // R18
        end
      end
    end
  endgenerate

  // fault bits of the byte follow the line check only
  logic [7:0] next_byte;
  always_comb
  begin
    next_byte = BYTE_RESET;
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_byte[STATE_BIT0 + BITS_PER_CH*i] = cond_bit[i]; // R1
      next_byte[FAULT_BIT0 + BITS_PER_CH*i] = line_fault_check_en[i] && (line_status[2*i +: 2] != LF_OK); // R1
    end
  end

  wire any_line_fault = |(line_fault_check_en & {line_status[4] | line_status[5],
    line_status[2] | line_status[3], line_status[0] | line_status[1]});
  logic [1:0] first_ch;
  always_comb
  begin
    first_ch = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (line_fault_check_en[i] && line_status[2*i +: 2] != LF_OK)
        first_ch = 2'(i);
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      input_byte <= BYTE_RESET;
      input_byte_valid <= 1'b0;
      config_code <= 8'h00;
      module_fault <= 1'b0;
      global_fault <= 1'b0;
      channel_invalid <= '0;
      diag_valid <= 1'b0;
      diag_slot <= 8'h00;
      diag_channel <= 2'h0;
      diag_is_input <= 1'b0;
      diag_reason <= LF_OK;
    end
    else if (clk_en)
    begin
      config_code <= CONFIG_CODE; // R2
      input_byte_valid <= fwd_due; // R3
      if (fwd_due)
        input_byte <= next_byte; // R3 R4
      module_fault <= diag_status_en && any_line_fault; // R10
      global_fault <= diag_status_en && any_line_fault; // R10
      channel_invalid <= inval_bit; // R21
      diag_valid <= any_line_fault; // R9 R12
      diag_slot <= SLOT_ID; // R11
      diag_channel <= first_ch; // R11
      diag_is_input <= 1'b1; // R11
      diag_reason <= any_line_fault ? line_status[2*first_ch +: 2] : LF_OK; // R11
    end
  end

  property p_fwd_period;
    @(posedge clock) disable iff (sys_rst || !clk_en)
    input_byte_valid |=> !input_byte_valid;
  endproperty
  a_fwd_period: assert property (p_fwd_period) else $error("forward strobe longer than one cycle"); // R3

  property p_byte_pad;
    @(posedge clock) disable iff (sys_rst)
    input_byte[7:6] == 2'b00;
  endproperty
  a_byte_pad: assert property (p_byte_pad) else $error("empty bits of input byte set"); // R1

  property p_code;
    @(posedge clock) disable iff (sys_rst)
    ($past(clk_en) && !$past(sys_rst)) |-> config_code == CONFIG_CODE;
  endproperty
  a_code: assert property (p_code) else $error("configuration code wrong"); // R2

  property p_fault_bit;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && fwd_due) |=> input_byte[1] == $past(line_fault_check_en[0] && line_status[1:0] != LF_OK);
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit channel one wrong"); // R1 R7

  property p_mod_fault;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !diag_status_en) |=> !module_fault && !global_fault;
  endproperty
  a_mod_fault: assert property (p_mod_fault) else $error("module fault shown while disabled"); // R10

  property p_diag;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && any_line_fault) |=> diag_valid && diag_reason != LF_OK && diag_is_input;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnosis missing"); // R9 R11

  property p_subst;
    @(posedge clock) disable iff (sys_rst)
    (fault_mode[1:0] == DIC_FM_SUBST && fault_bit[0]) |-> cond_bit[0] == subst_value[0];
  endproperty
  a_subst: assert property (p_subst) else $error("substitute value not passed"); // R17

  property p_sim;
    @(posedge clock) disable iff (sys_rst)
    (sim_mode[0] && !fault_bit[0]) |-> cond_bit[0] == sim_value[0];
  endproperty
  a_sim: assert property (p_sim) else $error("simulation value not passed"); // R15 R22

  property p_zero_delay;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !sys_rst && on_delay_ms[DELAY_W-1:0] == '0 && off_delay_ms[DELAY_W-1:0] == '0 && $stable(clk_en))
      ##1 clk_en |-> delayed[0] == $past(closed_is_one[0] ? field_level[0] : ~field_level[0]);
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not transparent"); // R19 R20

  sequence s_due;
    clk_en && fwd_due;
  endsequence
  sequence s_strobe;
    input_byte_valid && input_byte[7:6] == 2'b00;
  endsequence
  property p_strobe;
    @(posedge clock) disable iff (sys_rst)
    s_due |=> s_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("forward strobe missing after due count"); // R3

  property p_no_strobe;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !fwd_due) |=> !input_byte_valid;
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("forward strobe outside its period"); // R3

  property p_freeze;
    @(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(input_byte) && $stable(input_byte_valid) && $stable(diag_valid) && $stable(channel_invalid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while clock enable low"); // R3

  sequence s_fault0;
    clk_en && fault_bit[0];
  endsequence
  property p_last_hold;
    @(posedge clock) disable iff (sys_rst)
    s_fault0 |=> $stable(last_good[0]);
  endproperty
  a_last_hold: assert property (p_last_hold) else $error("last valid value changed during fault"); // R18

  property p_inval;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !sys_rst) |=> channel_invalid[0] == $past(fault_bit[0] && fault_mode[1:0] == DIC_FM_SUBST && subst_invalid[0]);
  endproperty
  a_inval: assert property (p_inval) else $error("substitute status not reported"); // R21

  // with the counter at zero and a delay of two or more, no edge may pass yet
  sequence s_rise_pending;
    clk_en && !sys_rst && on_delay_ms[2*DELAY_W-1:DELAY_W] > 1 && !delayed[1] && dly_cnt[2*DELAY_W-1:DELAY_W] == '0;
  endsequence
  property p_on_hold;
    @(posedge clock) disable iff (sys_rst)
    s_rise_pending |=> !delayed[1];
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("rising edge passed before on delay"); // R19 R24

  property p_off_hold;
    @(posedge clock) disable iff (sys_rst)
    (clk_en && !sys_rst && off_delay_ms[3*DELAY_W-1:2*DELAY_W] > 1 && delayed[2] && dly_cnt[3*DELAY_W-1:2*DELAY_W] == '0)
      |=> delayed[2];
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("falling edge passed before off delay"); // R5 R20
endmodule // dic_conditioner
`default_nettype wire

// >>> sim/dic_comm_unit.sv
// Purpose: station unit model taking the forwarded input byte
// Assumes: one valid pulse per forward period
// Notes: gap holds the cycle count between the last two frames
`default_nettype none
module dic_comm_unit (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] input_byte,
  input wire logic input_byte_valid,
  output logic [7:0] rx_byte,
  output int gap
);
  timeunit 1ns;
  timeprecision 1ns;
  int since;
  // the unit only listens; it never stalls the module
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_byte <= 8'h00;
      gap <= 0;
      since <= 0;
    end
    else
    begin
      since <= input_byte_valid ? 0 : since + 1;
      if (input_byte_valid)
      begin
        rx_byte <= input_byte;
        gap <= since + 1;
      end
    end
  end
endmodule // dic_comm_unit
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: random and corner checks of the input conditioner
// Assumes: short tick and forward counts to keep the run brief
// Notes: last-valid mode is kept out of the random loop, it is stateful
`default_nettype none
module tb_top import dic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  localparam int FW = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic dse = 1'b0;
  logic [2:0] fl = 3'h0, lce = 3'h0, poli = 3'h0, sm = 3'h0, sv = 3'h0, si = 3'h0, subv = 3'h0, subi = 3'h0;
  logic [5:0] ls = 6'h00, fm = 6'h00;
  logic [47:0] ond = 48'h0, offd = 48'h0;
  wire [7:0] ib, cc, dslot, rxb;
  wire ibv, mf, gf, dv, dio;
  wire [1:0] dch, drs;
  wire [2:0] cinv;
  int gap, n_fail, compares, cyc, j;
  logic [31:0] r;
  logic [7:0] e;
  logic f;
  dic_conditioner #(.DELAY_W(16), .TICK_CYCLES(TK), .FWD_CYCLES(FW), .SLOT_ID(8'h03)) i_dic_conditioner (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .field_level(fl), .line_status(ls),
    .line_fault_check_en(lce), .closed_is_one(poli), .sim_mode(sm), .sim_value(sv), .sim_invalid(si),
    .fault_mode(fm), .subst_value(subv), .subst_invalid(subi), .on_delay_ms(ond), .off_delay_ms(offd),
    .diag_status_en(dse), .input_byte(ib), .input_byte_valid(ibv), .config_code(cc), .module_fault(mf),
    .global_fault(gf), .channel_invalid(cinv), .diag_valid(dv), .diag_slot(dslot), .diag_channel(dch),
    .diag_is_input(dio), .diag_reason(drs));
  dic_comm_unit i_dic_comm_unit (.clock(clock), .sys_rst(sys_rst), .input_byte(ib),
    .input_byte_valid(ibv), .rx_byte(rxb), .gap(gap));
  initial
  begin
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    compares++;
    if (got !== ex)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  // returns just after the edge that loaded a new byte
  task automatic frame();
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      #1;
      k++;
    end
    while (ibv !== 1'b1 && k < 100);
  endtask
  function automatic logic [7:0] exp_byte();
    logic [7:0] b;
    logic v, lf;
    b = 8'h00;
    for (int i = 0; i < 3; i++)
    begin
      v = sm[i] ? sv[i] : ~(fl[i] ^ poli[i]);
      lf = lce[i] && ls[2*i +: 2] != 2'h0;
      if ((lf || (sm[i] && si[i])) && fm[2*i +: 2] == 2'h1)
        v = subv[i];
      b[2*i] = v;
      b[2*i+1] = lf;
    end
    return b;
  endfunction
  function automatic logic [2:0] exp_inval();
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      m[i] = ((lce[i] && ls[2*i +: 2] != 2'h0) || (sm[i] && si[i])) && fm[2*i +: 2] == 2'h1 && subi[i];
    end
    return m;
  endfunction
  // ceiling well above the roughly 1900 cycles the sequence needs
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    r = $urandom(32'h75b1d81a);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (40)
    begin
      @(posedge clock);
      r = $urandom;
      {dse, lce, poli, sm, sv, si, subv, subi, fl} <= r[24:0];
      ls <= r[30:25];
      r = $urandom;
      fm <= r[5:0] | {1'b0, r[5], 1'b0, r[3], 1'b0, r[1]};
      frame();
      frame();
      e = exp_byte();
      f = |(e & 8'h2A);
      j = e[1] ? 0 : (e[3] ? 1 : 2);
      chk("byte", e, ib);
      chk("rx", e, rxb);
      chk("mflt", {7'h0, dse & f}, {7'h0, mf});
      chk("gflt", {7'h0, dse & f}, {7'h0, gf});
      chk("diag", {7'h0, f}, {7'h0, dv});
      chk("cinv", {5'h0, exp_inval()}, {5'h0, cinv});
      if (f)
        chk("dgn", {1'b1, j[1:0], ls[2*j +: 2], 3'h0}, {dio, dch, drs, 3'h0});
    end
    chk("cfg", 8'h0A, cc);
    chk("gap", FW[7:0], gap[7:0]);
    chk("slot", 8'h03, dslot);
    // ten frozen edges must push the next strobe ten cycles later
    @(posedge clock);
    clk_en <= 1'b0;
    repeat (9) @(posedge clock);
    #1;
    chk("frz_v", 8'h00, {7'h0, ibv});
    chk("frz_b", e, ib);
    @(posedge clock);
    clk_en <= 1'b1;
    frame();
    @(posedge clock);
    #1;
    chk("gap_frz", FW[7:0] + 8'h0A, gap[7:0]);
    @(posedge clock);
    {dse, lce, poli, sm, si, fl} <= {1'b0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h1};
    ls <= 6'h00;
    fm <= 6'h02;
    frame();
    frame();
    chk("pre", 8'h01, ib);
    @(posedge clock);
    ls <= 6'h01;
    @(posedge clock);
    fl <= 3'h0;
    frame();
    frame();
    chk("last", 8'h03, ib);
    @(posedge clock);
    {ls, fm, lce} <= 15'h0000;
    offd <= {16'h000A, 32'h0};
    frame();
    @(posedge clock);
    fl <= 3'h4;
    repeat (2) @(posedge clock);
    fl <= 3'h0;
    frame();
    chk("offd", 8'h10, ib);
    @(posedge clock);
    ond <= {16'h0000, 16'h000A, 16'h0000};
    // bounce shorter than the on delay must never get through
    repeat (6)
    begin
      @(posedge clock);
      fl <= 3'h2;
      repeat (8) @(posedge clock);
      fl <= 3'h0;
      repeat (3) @(posedge clock);
    end
    frame();
    chk("bnc", 8'h00, ib);
    @(posedge clock);
    fl <= 3'h2;
    repeat (4) frame();
    chk("ond", 8'h04, ib);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
